// [hw/pdfp_pack.sv]
/*
 * pdfp_pack: combinational dither and framebuffer-word pack of one fragment.
 * Assumes control fields come steady from the register through pdfp_ctl_if.
 */
`timescale 1ns/1ps
`default_nettype none
module pdfp_pack (
    // control
    pdfp_ctl_if.dst ctl,
    // fragment in
    input wire logic [7:0] red,
    input wire logic [7:0] green,
    input wire logic [7:0] blue,
    input wire logic [7:0] alpha,
    input wire logic [1:0] pix_x,
    input wire logic [1:0] pix_y,
    // packed out
    output logic [31:0] word,
    output logic [7:0] alpha_int
);
    logic [1:0] dx;
    logic [1:0] dy;
    logic [3:0] thr;
    logic [2:0] rw;
    logic [2:0] gw;
    logic [2:0] bw;
    logic [2:0] aw;
    logic [7:0] rq;
    logic [7:0] gq;
    logic [7:0] bq;
    logic [7:0] aq;
    logic [7:0] a_sel;
    logic [15:0] half;
    logic [6:0] low7;

    assign dx = ctl.dither_window_shift_x + pix_x;
    assign dy = ctl.dither_window_shift_y + pix_y;

    // ordered uses a 4x4 bayer cell, line uses the row only
    always_comb
    begin
        case ({dy, dx})
            4'h0: thr = 4'h0; 4'h1: thr = 4'h8; 4'h2: thr = 4'h2; 4'h3: thr = 4'ha;
            4'h4: thr = 4'hc; 4'h5: thr = 4'h4; 4'h6: thr = 4'he; 4'h7: thr = 4'h6;
            4'h8: thr = 4'h3; 4'h9: thr = 4'hb; 4'ha: thr = 4'h1; 4'hb: thr = 4'h9;
            4'hc: thr = 4'hf; 4'hd: thr = 4'h7; 4'he: thr = 4'hd; default: thr = 4'h5;
        endcase
        if (ctl.line_dither)
        begin
            thr = {dy, 2'h0};
        end
    end

    // channel widths per layout, ordering independent
    always_comb
    begin
        case (ctl.layout)
            pdfp_pkg::PDFP_L8888: begin rw = 3'h0; gw = 3'h0; bw = 3'h0; aw = 3'h0; end
            pdfp_pkg::PDFP_L5551F, pdfp_pkg::PDFP_L5551B:
                begin rw = 3'h5; gw = 3'h5; bw = 3'h5; aw = 3'h1; end
            pdfp_pkg::PDFP_L4444: begin rw = 3'h4; gw = 3'h4; bw = 3'h4; aw = 3'h4; end
            pdfp_pkg::PDFP_L332F, pdfp_pkg::PDFP_L332B:
                begin rw = 3'h3; gw = 3'h3; bw = 3'h2; aw = 3'h0; end
            pdfp_pkg::PDFP_L2321F, pdfp_pkg::PDFP_L2321B:
                begin rw = 3'h2; gw = 3'h3; bw = 3'h2; aw = 3'h1; end
            pdfp_pkg::PDFP_L565F, pdfp_pkg::PDFP_L565B:
                begin rw = 3'h5; gw = 3'h6; bw = 3'h5; aw = 3'h0; end
            default: begin rw = 3'h2; gw = 3'h3; bw = 3'h2; aw = 3'h0; end
        endcase
    end

    // the 8-bit fields are treated alike for 5.3 and integer use
    function automatic logic [7:0] quant(input logic [7:0] c, input logic [2:0] w,
        input logic [3:0] t, input logic en);
        logic [8:0] s;
        logic [8:0] d;
        s = 9'h000;
        d = 9'h000;
        if (w == 3'h0)
        begin
            quant = c;
        end
        else
        begin
            // add threshold only when dithering, scaled below one step
            d = en ? 9'({t, 4'h0} >> w) : 9'h000;
            s = {1'b0, c} + d;
            if (s[8])
            begin
                s = 9'h0ff;
            end
            quant = s[7:0] >> (4'h8 - {1'b0, w});
        end
    endfunction

    assign rq = quant(red, rw, thr, ctl.dither_en);
    assign gq = quant(green, gw, thr, ctl.dither_en);
    assign bq = quant(blue, bw, thr, ctl.dither_en);

    always_comb
    begin
        case (ctl.alpha_override_select)
            pdfp_pkg::PDFP_FA_ZERO: a_sel = 8'h00;
            pdfp_pkg::PDFP_FA_CONST: a_sel = pdfp_pkg::PDFP_ALPHA_DEFAULT;
            default: a_sel = alpha;
        endcase
        if (aw == 3'h0 && ctl.layout != pdfp_pkg::PDFP_L8888)
        begin
            a_sel = pdfp_pkg::PDFP_ALPHA_DEFAULT;
        end
    end
    assign alpha_int = a_sel;
    assign aq = quant(a_sel, aw, 4'h0, 1'b0);

    // channel placement, red and blue swap with order bit
    always_comb
    begin
        logic [7:0] lo;
        logic [7:0] hi;
        lo = ctl.rgb_order ? bq : rq;
        hi = ctl.rgb_order ? rq : bq;
        half = 16'h0000;
        low7 = 7'h00;
        word = 32'h0000_0000;
        case (ctl.layout)
            pdfp_pkg::PDFP_L8888: word = {aq, hi, gq, lo};
            pdfp_pkg::PDFP_L5551F, pdfp_pkg::PDFP_L5551B:
                half = {aq[0], hi[4:0], gq[4:0], lo[4:0]};
            pdfp_pkg::PDFP_L4444: word = {16'h0000, aq[3:0], hi[3:0], gq[3:0], lo[3:0]};
            pdfp_pkg::PDFP_L332F, pdfp_pkg::PDFP_L332B:
                half = ctl.rgb_order ? {8'h00, rq[2:0], gq[2:0], bq[1:0]}
                                     : {8'h00, bq[1:0], gq[2:0], rq[2:0]};
            pdfp_pkg::PDFP_L2321F, pdfp_pkg::PDFP_L2321B:
                half = {8'h00, aq[0], hi[1:0], gq[2:0], lo[1:0]};
            pdfp_pkg::PDFP_L232FO, pdfp_pkg::PDFP_L232BO:
            begin
                // bias of 64 on the 7-bit value
                low7 = {hi[1:0], gq[2:0], lo[1:0]} + pdfp_pkg::PDFP_OFFSET_BIAS;
                half = {8'h00, 1'b0, low7};
            end
            pdfp_pkg::PDFP_L565F, pdfp_pkg::PDFP_L565B:
                half = {hi[4:0], gq[5:0], lo[4:0]};
            pdfp_pkg::PDFP_LCI8: word = {4{red}};
            default: word = 32'h0000_0000;
        endcase
        // front and back replicate the packed value
        case (ctl.layout)
            pdfp_pkg::PDFP_L5551F, pdfp_pkg::PDFP_L5551B, pdfp_pkg::PDFP_L565F,
            pdfp_pkg::PDFP_L565B:
                word = {2{half}};
            pdfp_pkg::PDFP_L332F, pdfp_pkg::PDFP_L332B, pdfp_pkg::PDFP_L2321F,
            pdfp_pkg::PDFP_L2321B, pdfp_pkg::PDFP_L232FO, pdfp_pkg::PDFP_L232BO:
                word = {2{half[7:0], half[7:0]}};
            default: word = word;
        endcase
    end
endmodule
`default_nettype wire

// [pkg/pdfp_pkg.sv]
/*
 * pdfp_pkg: constants and types for the dither and pixel-format pack stage.
 * Assumes a single core clock; every user writes pdfp_pkg::name.
 */
package pdfp_pkg;
    // register map
    localparam logic [3:0] PDFP_ADDR_CONTROL = 4'h0;
    localparam logic [31:0] PDFP_CONTROL_RESET = 32'h0000_0000;
    // control field positions
    localparam int PDFP_BIT_DITHER_EN = 1;
    localparam int PDFP_FMT_LO = 2;
    localparam int PDFP_FMT_HI = 5;
    localparam int PDFP_XSH_LO = 6;
    localparam int PDFP_XSH_HI = 7;
    localparam int PDFP_YSH_LO = 8;
    localparam int PDFP_YSH_HI = 9;
    localparam int PDFP_BIT_RGB = 10;
    localparam int PDFP_BIT_LINE = 11;
    localparam int PDFP_ALPHA_LO = 12;
    localparam int PDFP_ALPHA_HI = 13;
    localparam int PDFP_BIT_FMT_EXT = 16;
    // constants
    localparam logic [7:0] PDFP_ALPHA_DEFAULT = 8'hf8;
    localparam logic [6:0] PDFP_OFFSET_BIAS = 7'h40;
    localparam logic [1:0] PDFP_FA_KEEP = 2'h0;
    localparam logic [1:0] PDFP_FA_ZERO = 2'h1;
    localparam logic [1:0] PDFP_FA_CONST = 2'h2;
    // layout codes
    localparam logic [4:0] PDFP_L8888 = 5'h00;
    localparam logic [4:0] PDFP_L5551F = 5'h01;
    localparam logic [4:0] PDFP_L4444 = 5'h02;
    localparam logic [4:0] PDFP_L332F = 5'h05;
    localparam logic [4:0] PDFP_L332B = 5'h06;
    localparam logic [4:0] PDFP_L2321F = 5'h09;
    localparam logic [4:0] PDFP_L2321B = 5'h0a;
    localparam logic [4:0] PDFP_L232FO = 5'h0b;
    localparam logic [4:0] PDFP_L232BO = 5'h0c;
    localparam logic [4:0] PDFP_L5551B = 5'h0d;
    localparam logic [4:0] PDFP_LCI8 = 5'h0e;
    localparam logic [4:0] PDFP_L565F = 5'h10;
    localparam logic [4:0] PDFP_L565B = 5'h11;
    // pipeline state
    typedef enum logic [0:0] {
        PDFP_IDLE = 1'b0,
        PDFP_FULL = 1'b1
    } pdfp_state_t;
endpackage

// [pkg/pdfp_ctl_if.sv]
/*
 * pdfp_ctl_if: decoded control fields passed from the register to the pack unit.
 * Assumes one driver (the top) and one reader (the pack module).
 */
`timescale 1ns/1ps
`default_nettype none
interface pdfp_ctl_if;
    logic dither_en;
    logic [4:0] layout;
    logic [1:0] dither_window_shift_x;
    logic [1:0] dither_window_shift_y;
    logic rgb_order;
    logic line_dither;
    logic [1:0] alpha_override_select;
    modport src (output dither_en, layout, dither_window_shift_x, dither_window_shift_y,
        rgb_order, line_dither, alpha_override_select);
    modport dst (input dither_en, layout, dither_window_shift_x, dither_window_shift_y,
        rgb_order, line_dither, alpha_override_select);
endinterface
`default_nettype wire

// [hw/pdfp_top.sv]
/*
 * pdfp_top: control register, one-stage pipeline and register read port.
 * Assumes upstream holds a fragment while in_ready is low; bus strobes
 * are one cycle and never together.
 */
`timescale 1ns/1ps
`default_nettype none
module pdfp_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // fragment in
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_red,
    input wire logic [7:0] in_green,
    input wire logic [7:0] in_blue,
    input wire logic [7:0] in_alpha,
    input wire logic [1:0] in_x,
    input wire logic [1:0] in_y,
    // packed out
    output logic out_valid,
    input wire logic out_ready,
    output logic [31:0] out_word,
    output logic [7:0] out_alpha
);
    typedef struct packed {
        logic [31:0] control;
        logic [31:0] rdata;
        pdfp_pkg::pdfp_state_t state;
        logic [31:0] word;
        logic [7:0] alpha;
    } pdfp_regs_t;

    pdfp_regs_t st_reg;
    pdfp_regs_t st_next;
    pdfp_ctl_if ctl ();
    logic [31:0] pk_word;
    logic [7:0] pk_alpha;
    logic take;

    // layout code with extension bit on top
    assign ctl.layout = {st_reg.control[pdfp_pkg::PDFP_BIT_FMT_EXT],
        st_reg.control[pdfp_pkg::PDFP_FMT_HI:pdfp_pkg::PDFP_FMT_LO]};
    assign ctl.dither_en = st_reg.control[pdfp_pkg::PDFP_BIT_DITHER_EN];
    assign ctl.dither_window_shift_x =
        st_reg.control[pdfp_pkg::PDFP_XSH_HI:pdfp_pkg::PDFP_XSH_LO];
    assign ctl.dither_window_shift_y =
        st_reg.control[pdfp_pkg::PDFP_YSH_HI:pdfp_pkg::PDFP_YSH_LO];
    assign ctl.rgb_order = st_reg.control[pdfp_pkg::PDFP_BIT_RGB];
    assign ctl.line_dither = st_reg.control[pdfp_pkg::PDFP_BIT_LINE];
    assign ctl.alpha_override_select =
        st_reg.control[pdfp_pkg::PDFP_ALPHA_HI:pdfp_pkg::PDFP_ALPHA_LO];

    pdfp_pack u_pack (
        .ctl(ctl),
        .red(in_red),
        .green(in_green),
        .blue(in_blue),
        .alpha(in_alpha),
        .pix_x(in_x),
        .pix_y(in_y),
        .word(pk_word),
        .alpha_int(pk_alpha)
    );

    // stage accepts when empty or draining this cycle
    assign in_ready = (st_reg.state == pdfp_pkg::PDFP_IDLE) || out_ready;
    assign take = in_valid && in_ready;
    assign out_valid = (st_reg.state == pdfp_pkg::PDFP_FULL);
    assign out_word = st_reg.word;
    assign out_alpha = st_reg.alpha;
    assign reg_rdata = st_reg.rdata;

    // next state; reads return data only in the following cycle
    always_comb
    begin
        st_next = st_reg;
        st_next.rdata = 32'h0000_0000;
        if (reg_wr && reg_addr == pdfp_pkg::PDFP_ADDR_CONTROL)
        begin
            st_next.control = reg_wdata;
        end
        if (reg_rd && reg_addr == pdfp_pkg::PDFP_ADDR_CONTROL)
        begin
            st_next.rdata = st_reg.control;
        end
        case (st_reg.state)
            pdfp_pkg::PDFP_IDLE:
                if (take)
                begin
                    st_next.state = pdfp_pkg::PDFP_FULL;
                end
            pdfp_pkg::PDFP_FULL:
                if (out_ready && !take)
                begin
                    st_next.state = pdfp_pkg::PDFP_IDLE;
                end
            default: st_next.state = pdfp_pkg::PDFP_IDLE;
        endcase
        if (take)
        begin
            st_next.word = pk_word;
            st_next.alpha = pk_alpha;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '{control: pdfp_pkg::PDFP_CONTROL_RESET, rdata: 32'h0000_0000,
                state: pdfp_pkg::PDFP_IDLE, word: 32'h0000_0000, alpha: 8'h00};
        end
        else
        begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire

// [test/pdfp_props.sv]
/*
 * pdfp_props: checker on the ports of the pack stage top.
 * Assumes control is rewritten only while the stage is empty.
 */
`timescale 1ns/1ps
`default_nettype none
module pdfp_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // stream
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [31:0] out_word,
    input wire logic [7:0] out_alpha
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] ctl_reg;
    logic [4:0] lay;
    ////////////////////////////////////////////////////////////
    // shadow of the control register, only index 0 is mapped
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctl_reg <= 32'h0;
        else if (reg_wr && reg_addr == pdfp_pkg::PDFP_ADDR_CONTROL)
            ctl_reg <= reg_wdata;
    end
    assign lay = {ctl_reg[16], ctl_reg[5:2]}; // layout code as the stage forms it
    ////////////////////////////////////////////////////////////
    a_read_back: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(ctl_reg))
        else $error("control read data wrong");
    a_read_zero: assert property (!reg_rd || reg_addr != 4'h0 |=> reg_rdata == 32'h0)
        else $error("read data not zero");
    a_stall_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word)
        && $stable(out_alpha)) else $error("output changed while stalled");
    a_ready_rule: assert property (in_ready == (!out_valid || out_ready))
        else $error("in_ready wrong");
    a_take_answer: assert property (in_valid && in_ready |=> out_valid)
        else $error("accepted fragment gave no output");
    a_byte_copy:
        assert property (out_valid && lay == pdfp_pkg::PDFP_LCI8 |-> out_word == {4{out_word[7:0]}})
        else $error("index not in every byte");
    a_half_dup:
        assert property (out_valid && lay == pdfp_pkg::PDFP_L565F |->
        out_word[31:16] == out_word[15:0]) else $error("halves differ");
    a_no_alpha:
        assert property (out_valid && lay == pdfp_pkg::PDFP_L565F |-> out_alpha == 8'hf8)
        else $error("alpha default missing");
    a_alpha_zero:
        assert property (out_valid && lay == 5'h00 && ctl_reg[13:12] == 2'h1 |->
        out_alpha == 8'h00 && out_word[31:24] == 8'h00) else $error("alpha not forced to zero");
    a_bias_add:
        assert property (out_valid && lay == pdfp_pkg::PDFP_L232FO |-> out_word[7:0] >= 8'h40)
        else $error("bias missing");
endmodule
bind pdfp_top pdfp_props pdfp_props_i (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .in_valid, .in_ready, .out_valid, .out_ready, .out_word, .out_alpha);
`default_nettype wire

// [test/pdfp_sink.sv]
/*
 * pdfp_sink: model of the framebuffer write stage taking packed words.
 * Assumes the bench picks prompt or stalling mode through slow.
 */
`timescale 1ns/1ps
`default_nettype none
module pdfp_sink (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // mode from the bench
    input wire logic slow,
    // stream
    output logic out_ready
);
    logic [31:0] lfsr;
    // pseudo-random stalls, so holds under back-pressure get exercised
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lfsr <= 32'h0badf00d;
            out_ready <= 1'b0;
        end
        else
        begin
            lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            out_ready <= !slow || lfsr[0];
        end
    end
endmodule
`default_nettype wire

// [test/testbench.sv]
/*
 * testbench: self-checking bench of the pack stage with a stalling sink.
 * Assumes pdfp_props is bound to pdfp_top.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk, rst_n, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready, slow;
    logic rd_prev;
    logic [3:0] reg_addr;
    logic [4:0] l;
    logic [31:0] reg_wdata, reg_rdata, out_word, ctl, seed;
    logic [7:0] in_red, in_green, in_blue, in_alpha, out_alpha;
    logic [1:0] in_x, in_y;
    logic [39:0] pq[$];
    logic [31:0] rq[$];
    int n_fail, n_tests, cyc;
    logic [4:0] lays [12] = '{5'h00, 5'h10, 5'h01, 5'h05, 5'h0b, 5'h0e, 5'h02, 5'h09, 5'h11,
        5'h0d, 5'h06, 5'h03};
    // ordered dither cell, row picked by y and column by x
    logic [3:0] bayer [16] = '{4'h0, 4'h8, 4'h2, 4'ha, 4'hc, 4'h4, 4'he, 4'h6, 4'h3, 4'hb, 4'h1,
        4'h9, 4'hf, 4'h7, 4'hd, 4'h5};
    pdfp_top pdfp_top_i (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .in_valid, .in_ready, .in_red, .in_green, .in_blue, .in_alpha, .in_x, .in_y,
        .out_valid, .out_ready, .out_word, .out_alpha);
    pdfp_sink pdfp_sink_i (.sys_clk, .rst_n, .slow, .out_ready);
    ////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // threshold scaled below one step, saturating add, then truncation to w bits
    function automatic logic [7:0] dq(input logic [7:0] x, input int w, input logic [3:0] t,
        input logic en);
        logic [8:0] s;
        s = {1'b0, x} + (en ? 9'({t, 4'h0} >> w) : 9'h000);
        if (s[8])
            s = 9'h0ff;
        return s[7:0] >> (8 - w);
    endfunction
    // expected {alpha, word} of one fragment: control c, colour v, coordinates xy = {x, y}
    function automatic logic [39:0] ref_px(input logic [31:0] c, input logic [31:0] v,
        input logic [3:0] xy);
        logic [4:0] l;
        logic [3:0] t;
        logic [1:0] px, py;
        logic [15:0] h;
        logic [7:0] r, g, b, a, p, r5, g5, b5, g6, r4, g4, b4, r3, g3, r2, b2;
        l = {c[16], c[5:2]};
        {a, b, g, r} = v;
        // window shift, line row or ordered cell
        px = xy[3:2] + c[7:6];
        py = xy[1:0] + c[9:8];
        t = c[11] ? {py, 2'h0} : bayer[{py, px}];
        r5 = dq(r, 5, t, c[1]);
        g5 = dq(g, 5, t, c[1]);
        b5 = dq(b, 5, t, c[1]);
        g6 = dq(g, 6, t, c[1]);
        r4 = dq(r, 4, t, c[1]);
        g4 = dq(g, 4, t, c[1]);
        b4 = dq(b, 4, t, c[1]);
        r3 = dq(r, 3, t, c[1]);
        g3 = dq(g, 3, t, c[1]);
        r2 = dq(r, 2, t, c[1]);
        b2 = dq(b, 2, t, c[1]);
        a = (c[13:12] == 2'h1) ? 8'h00 : (c[13:12] == 2'h2) ? 8'hf8 : a;
        if (!(l inside {5'h00, 5'h01, 5'h02, 5'h09, 5'h0d}))
            a = 8'hf8;
        h = 16'h0000;
        p = 8'h00;
        case (l)
            5'h00: return {a, a, c[10] ? {r, g, b} : {b, g, r}};
            5'h02: return {a, 16'h0000, a[7:4],
                c[10] ? {r4[3:0], g4[3:0], b4[3:0]} : {b4[3:0], g4[3:0], r4[3:0]}};
            5'h10, 5'h11: h = c[10] ? {r5[4:0], g6[5:0], b5[4:0]} : {b5[4:0], g6[5:0], r5[4:0]};
            5'h01, 5'h0d: h = {a[7],
                c[10] ? {r5[4:0], g5[4:0], b5[4:0]} : {b5[4:0], g5[4:0], r5[4:0]}};
            5'h05, 5'h06: p = c[10] ? {r3[2:0], g3[2:0], b2[1:0]} : {b2[1:0], g3[2:0], r3[2:0]};
            5'h09: p = {a[7], c[10] ? {r2[1:0], g3[2:0], b2[1:0]} : {b2[1:0], g3[2:0], r2[1:0]}};
            // bias of 64 on the 7-bit value
            5'h0b: p = {1'b0, 7'(7'h40 +
                (c[10] ? {r2[1:0], g3[2:0], b2[1:0]} : {b2[1:0], g3[2:0], r2[1:0]}))};
            5'h0e: p = r;
            default: return {a, 32'h0000_0000};
        endcase
        if (l inside {5'h10, 5'h11, 5'h01, 5'h0d})
            return {a, h, h};
        return {a, {4{p}}};
    endfunction
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask
    // fragment held until the edge at which in_ready is high
    task automatic send(input logic [31:0] c);
        logic [31:0] v;
        seed = xs(seed);
        v = (c[5:2] == 4'hb) ? seed & 32'hff3fff3f : seed; // biased sum below 0x80 with dither
        in_valid <= 1'b1;
        {in_alpha, in_blue, in_green, in_red} <= v;
        {in_x, in_y} <= seed[11:8];
        pq.push_back(ref_px(c, v, seed[11:8]));
        @(negedge sys_clk);
        while (!in_ready)
            @(negedge sys_clk);
        @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////
    // watcher: results compared against the oldest note, hang limit
    always @(negedge sys_clk)
    begin
        if (rd_prev)
            check({8'h0, reg_rdata}, {8'h0, rq.pop_front()});
        rd_prev = reg_rd;
        if (out_valid && out_ready)
            check({out_alpha, out_word}, pq.pop_front());
        cyc++;
        if (cyc > 20000)
        begin
            n_fail++;
            test_done();
        end
    end
    initial
    begin
        {reg_wr, reg_rd, in_valid, slow, rst_n, rd_prev} = '0;
        {reg_addr, reg_wdata, in_red, in_green, in_blue, in_alpha, in_x, in_y} = '0;
        seed = 32'h3d582e41;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(4'h0, pdfp_pkg::PDFP_CONTROL_RESET);
        @(posedge sys_clk);
        rd(4'h5, 32'h0);
        // every layout but L2321B and L232BO, each order and override, dither modes drawn from the seed
        for (int i = 0; i < 72; i++)
        begin
            seed = xs(seed);
            l = lays[i % 12];
            ctl = {15'h0, l[4], 2'h0, 2'(i / 24), seed[5], 1'((i / 12) % 2), seed[3:0], l[3:0],
                seed[4], 1'b0};
            slow <= i[0];
            wr(4'h0, ctl);
            rd(4'h0, ctl);
            repeat (4) send(ctl);
            in_valid <= 1'b0;
            while (pq.size() != 0)
                @(posedge sys_clk);
        end
        // unmapped write leaves control untouched
        wr(4'h7, 32'hffffffff);
        rd(4'h0, ctl);
        repeat (2) @(posedge sys_clk);
        test_done();
    end
endmodule
`default_nettype wire
